/* paoam_cfg.svh */
// Pin positions, reset values and widths of the port A override block
`ifndef PAOAM_CFG_SVH
`define PAOAM_CFG_SVH
`define PAOAM_PIN_COUNT   8
`define PAOAM_PIN_REF     0
`define PAOAM_PIN_CMP_POS 1
`define PAOAM_PIN_CMP_NEG 2
`define PAOAM_PIN_TMR0    3
`define PAOAM_PIN_SCLK    4
`define PAOAM_PIN_SDOUT   5
`define PAOAM_PIN_SDATA   6
`define PAOAM_PIN_CAPT    7
`define PAOAM_RST_BIT     1'b0
`define PAOAM_RST_PORT    8'h00
`define PAOAM_PULL_PATTERN 3'h2
`endif

/* paoam_pkg.sv */
// Types shared by the port A override block
package paoam_pkg;
  typedef logic [7:0] paoam_port_t;
  typedef logic [2:0] paoam_chan_t;
endpackage

/* paoam_pin.sv */
// One port pin: override resolution, input synchroniser and registered pad controls
`timescale 1ns/10ps
`include "paoam_cfg.svh"
module paoam_pin
  import paoam_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic rst_b,
  input  wire logic portBit,
  input  wire logic dirBit,
  input  wire logic globalPullupDisable,
  input  wire logic sleepActive,
  input  wire logic padIn,
  input  wire logic pullupOverrideEnable,
  input  wire logic pullupOverrideValue,
  input  wire logic directionOverrideEnable,
  input  wire logic directionOverrideValue,
  input  wire logic valueOverrideEnable,
  input  wire logic valueOverrideValue,
  input  wire logic toggleOverrideEnable,
  input  wire logic inputEnableOverrideEnable,
  input  wire logic inputEnableOverrideValue,
  output logic      pullupReg,
  output logic      driveReg,
  output logic      valueReg,
  output logic      inputEnReg,
  output logic      digInReg
);
  logic portEff;
  logic pullupNext;
  logic driveNext;
  logic valueNext;
  logic inputEnNext;
  logic syncFirst;
  logic syncSecond;

  always_comb begin
    portEff     = portBit ^ toggleOverrideEnable;
    pullupNext  = pullupOverrideEnable ? pullupOverrideValue
                : ({dirBit, portBit, globalPullupDisable} == `PAOAM_PULL_PATTERN);
    driveNext   = directionOverrideEnable ? directionOverrideValue : dirBit;
    valueNext   = valueOverrideEnable ? valueOverrideValue : portEff;
    inputEnNext = inputEnableOverrideEnable ? inputEnableOverrideValue : !sleepActive;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      pullupReg  <= `PAOAM_RST_BIT;
      driveReg   <= `PAOAM_RST_BIT;
      valueReg   <= `PAOAM_RST_BIT;
      inputEnReg <= `PAOAM_RST_BIT;
    end else begin
      pullupReg  <= pullupNext;
      driveReg   <= driveNext;
      valueReg   <= valueNext;
      inputEnReg <= inputEnNext;
    end
  end

  // Pad is asynchronous; only the second stage feeds the gate
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      syncFirst  <= `PAOAM_RST_BIT;
      syncSecond <= `PAOAM_RST_BIT;
      digInReg   <= `PAOAM_RST_BIT;
    end else begin
      syncFirst  <= padIn;
      syncSecond <= syncFirst;
      digInReg   <= syncSecond & inputEnNext;
    end
  end
endmodule

/* paoam_mux.sv */
// Port A alternate function override mux, top level
`timescale 1ns/10ps
`include "paoam_cfg.svh"
module paoam_mux
  import paoam_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire paoam_port_t portOut,
  input  wire paoam_port_t dirBits,
  input  wire paoam_port_t padIn,
  input  wire logic        globalPullupDisable,
  input  wire logic        sleepActive,
  input  wire logic        referenceSelectLow,
  input  wire logic        converterEnable,
  input  wire paoam_chan_t converterChannelSelect,
  input  wire logic        comparatorEnable,
  input  wire logic        wireModeHighBit,
  input  wire logic        wireModeLowBit,
  input  wire logic        serialDataOut,
  input  wire logic        serialDataLine,
  input  wire logic        serialStartIrqEnable,
  input  wire logic        timer1CompareAOut,
  input  wire logic        timer1CompareAEnable,
  input  wire logic        timer1CompareBOut,
  input  wire logic        timer1CompareBEnable,
  input  wire logic        timer0CompareBOut,
  input  wire logic        timer0CompareBEnable,
  input  wire paoam_port_t pinChangeMask,
  input  wire logic        pinChangeGroup0Enable,
  input  wire paoam_port_t digitalInputDisable,
  output paoam_port_t      padOut,
  output paoam_port_t      padOe,
  output paoam_port_t      pullupEn,
  output paoam_port_t      digInEn,
  output paoam_port_t      pinChangeSrc,
  output logic             timer0CountInput,
  output logic             timer1CountInput,
  output logic             serialIfaceClock,
  output logic             serialDataIn,
  output logic             timer1CaptureInput,
  output paoam_port_t      converterSwitch,
  output logic             comparatorPositiveInput,
  output logic             comparatorNegativeInput
);
  paoam_port_t pullupOverrideEnable;
  paoam_port_t pullupOverrideValue;
  paoam_port_t directionOverrideEnable;
  paoam_port_t directionOverrideValue;
  paoam_port_t valueOverrideEnable;
  paoam_port_t valueOverrideValue;
  paoam_port_t toggleOverrideEnable;
  paoam_port_t inputEnableOverrideEnable;
  paoam_port_t inputEnableOverrideValue;
  paoam_port_t changeEnabled;
  paoam_port_t digInBits;
  paoam_port_t converterSwitchReg;
  logic        compPosReg;
  logic        compNegReg;
  logic        bothModeBits;
  logic        pin6TwoWireDrive;

  function automatic paoam_port_t chanDecode(input paoam_chan_t sel);
    paoam_port_t oneHot;
    oneHot      = `PAOAM_RST_PORT;
    oneHot[sel] = 1'b1;
    return oneHot;
  endfunction

  always_comb begin
    bothModeBits     = wireModeHighBit & wireModeLowBit;
    pin6TwoWireDrive = wireModeHighBit & dirBits[`PAOAM_PIN_SDATA];
    changeEnabled    = pinChangeMask & {`PAOAM_PIN_COUNT{pinChangeGroup0Enable}};
    // Unlisted pull-up, direction, value and toggle terms stay zero; input enables follow the change and disable masks
    pullupOverrideEnable      = `PAOAM_RST_PORT;
    pullupOverrideValue       = `PAOAM_RST_PORT;
    directionOverrideEnable   = `PAOAM_RST_PORT;
    directionOverrideValue    = `PAOAM_RST_PORT;
    valueOverrideEnable       = `PAOAM_RST_PORT;
    valueOverrideValue        = `PAOAM_RST_PORT;
    toggleOverrideEnable      = `PAOAM_RST_PORT;
    inputEnableOverrideEnable = changeEnabled | digitalInputDisable;
    inputEnableOverrideValue  = changeEnabled;
    // Pin 0 becomes a reference: driver, pull-up and value all forced off
    pullupOverrideEnable[`PAOAM_PIN_REF]    = referenceSelectLow;
    directionOverrideEnable[`PAOAM_PIN_REF] = referenceSelectLow;
    valueOverrideEnable[`PAOAM_PIN_REF]     = referenceSelectLow;
    // Pin 5: pull-up left to the port path so the output bit still pulls up
    valueOverrideEnable[`PAOAM_PIN_SDOUT] = bothModeBits | timer1CompareBEnable;
    valueOverrideValue[`PAOAM_PIN_SDOUT]  = bothModeBits ? serialDataOut
                                          : timer1CompareBOut;
    // Pin 6: two-wire data acts open drain, value held low while wireModeHighBit and the pin 6 direction bit are both set
    directionOverrideEnable[`PAOAM_PIN_SDATA] = wireModeHighBit;
    directionOverrideValue[`PAOAM_PIN_SDATA]  = (serialDataLine | portOut[`PAOAM_PIN_SDATA])
                                              & dirBits[`PAOAM_PIN_SDATA];
    valueOverrideEnable[`PAOAM_PIN_SDATA] = pin6TwoWireDrive | timer1CompareAEnable;
    valueOverrideValue[`PAOAM_PIN_SDATA]  = !pin6TwoWireDrive & timer1CompareAOut;
    inputEnableOverrideEnable[`PAOAM_PIN_SDATA] = serialStartIrqEnable
                                                | changeEnabled[`PAOAM_PIN_SDATA]
                                                | digitalInputDisable[`PAOAM_PIN_SDATA];
    inputEnableOverrideValue[`PAOAM_PIN_SDATA]  = serialStartIrqEnable
                                                | changeEnabled[`PAOAM_PIN_SDATA];
    // Pin 7: driver stays with the direction bit
    valueOverrideEnable[`PAOAM_PIN_CAPT] = timer0CompareBEnable;
    valueOverrideValue[`PAOAM_PIN_CAPT]  = timer0CompareBOut;
  end

  genvar n;
  generate
    for (n = 0; n < `PAOAM_PIN_COUNT; n = n + 1) begin : g_pin
      paoam_pin u_pin (
        .core_clk                  (core_clk),
        .rst_b                     (rst_b),
        .portBit                   (portOut[n]),
        .dirBit                    (dirBits[n]),
        .globalPullupDisable       (globalPullupDisable),
        .sleepActive               (sleepActive),
        .padIn                     (padIn[n]),
        .pullupOverrideEnable      (pullupOverrideEnable[n]),
        .pullupOverrideValue       (pullupOverrideValue[n]),
        .directionOverrideEnable   (directionOverrideEnable[n]),
        .directionOverrideValue    (directionOverrideValue[n]),
        .valueOverrideEnable       (valueOverrideEnable[n]),
        .valueOverrideValue        (valueOverrideValue[n]),
        .toggleOverrideEnable      (toggleOverrideEnable[n]),
        .inputEnableOverrideEnable (inputEnableOverrideEnable[n]),
        .inputEnableOverrideValue  (inputEnableOverrideValue[n]),
        .pullupReg                 (pullupEn[n]),
        .driveReg                  (padOe[n]),
        .valueReg                  (padOut[n]),
        .inputEnReg                (digInEn[n]),
        .digInReg                  (digInBits[n])
      );
    end
  endgenerate

  // Digital inputs fan out straight from the per-pin flops
  assign pinChangeSrc       = digInBits;
  assign timer0CountInput   = digInBits[`PAOAM_PIN_TMR0];
  assign timer1CountInput   = digInBits[`PAOAM_PIN_SCLK];
  assign serialIfaceClock   = digInBits[`PAOAM_PIN_SCLK];
  assign serialDataIn       = digInBits[`PAOAM_PIN_SDATA];
  assign timer1CaptureInput = digInBits[`PAOAM_PIN_CAPT];

  // Analog switch controls; the analog path itself lives in the pad ring
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      converterSwitchReg <= `PAOAM_RST_PORT;
      compPosReg         <= `PAOAM_RST_BIT;
      compNegReg         <= `PAOAM_RST_BIT;
    end else begin
      converterSwitchReg <= converterEnable ? chanDecode(converterChannelSelect)
                                            : `PAOAM_RST_PORT;
      compPosReg         <= comparatorEnable;
      compNegReg         <= comparatorEnable;
    end
  end

  assign converterSwitch         = converterSwitchReg;
  assign comparatorPositiveInput = compPosReg;
  assign comparatorNegativeInput = compNegReg;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // Sampled rst_b in antecedents: the releasing edge still resets the flops

  sequence sPin7Live;
    (rst_b && padIn[`PAOAM_PIN_CAPT] && !sleepActive && !digitalInputDisable[`PAOAM_PIN_CAPT])[*4];
  endsequence

  sequence sThreeWireOut;
    rst_b && bothModeBits && dirBits[`PAOAM_PIN_SDOUT];
  endsequence

  a_ref_pin_off: assert property (referenceSelectLow |=> !pullupEn[0] && !padOe[0])
    else $error("Reference pin still pulled up or driven");
  a_serial_out_drive: assert property (sThreeWireOut ##0 serialDataOut |=> padOe[5] && padOut[5])
    else $error("Pin 5 not driving serial data-out");
  a_pin5_pullup_kept: assert property (
    rst_b && bothModeBits && !dirBits[5] && portOut[5] && !globalPullupDisable |=> pullupEn[5])
    else $error("Pin 5 pull-up lost in three-wire mode");
  a_capture_route: assert property (sPin7Live |-> timer1CaptureInput && pinChangeSrc[7])
    else $error("Pin 7 high not seen at capture input");
  a_count_route: assert property (timer0CountInput == pinChangeSrc[3]
                                  && timer1CountInput == pinChangeSrc[4]
                                  && serialIfaceClock == pinChangeSrc[4])
    else $error("Count inputs not routed from pins 3 and 4");
  a_channel_switch: assert property (rst_b && converterEnable |=>
    converterSwitch == chanDecode($past(converterChannelSelect)))
    else $error("Converter switch does not match channel");
  a_comparator_sw: assert property (rst_b && comparatorEnable |=>
    comparatorPositiveInput && comparatorNegativeInput)
    else $error("Comparator switches not closed");
  a_pin6_direction: assert property (rst_b && wireModeHighBit |=>
    padOe[6] == $past((serialDataLine | portOut[6]) & dirBits[6]))
    else $error("Pin 6 direction override wrong");
  a_pin5_compare: assert property (rst_b && !bothModeBits && timer1CompareBEnable |=>
    padOut[5] == $past(timer1CompareBOut))
    else $error("Pin 5 compare-B value wrong");
  a_pin7_compare: assert property (rst_b && timer0CompareBEnable |=>
    padOut[7] == $past(timer0CompareBOut) && padOe[7] == $past(dirBits[7]))
    else $error("Pin 7 compare-B value wrong");
  a_input_forced_off: assert property (digitalInputDisable[3] && !changeEnabled[3] |=> !digInEn[3])
    else $error("Converter disable did not turn input off");
  a_input_forced_on: assert property (rst_b && changeEnabled[2] |=> digInEn[2])
    else $error("Pin-change enable did not force input on");
  a_start_irq_input: assert property (rst_b && serialStartIrqEnable |=> digInEn[6])
    else $error("Start interrupt enable did not keep pin 6 input");
  a_plain_pull: assert property (rst_b && !referenceSelectLow |=>
    pullupEn[0] == ($past({dirBits[0], portOut[0], globalPullupDisable}) == 3'h2))
    else $error("Plain pull-up pattern wrong on pin 0");
  a_plain_path: assert property (rst_b && !wireModeHighBit && !timer1CompareAEnable |=>
    padOe[6] == $past(dirBits[6]) && padOut[6] == $past(portOut[6]))
    else $error("Pin 6 left the plain port path");
endmodule

/* paoam_pad_model.sv */
// Pad and external line model on the far side of port A
`timescale 1ns/10ps
module paoam_pad_model
  import paoam_pkg::*;
(
  input  wire paoam_port_t padOut,
  input  wire paoam_port_t padOe,
  input  wire paoam_port_t pullupEn,
  input  wire paoam_port_t extLevel,
  output paoam_port_t      padLevel
);
  // Own driver wins; an undriven line follows pull-up, else the outside level
  always_comb begin
    for (int n = 0; n < 8; n++) begin
      padLevel[n] = padOe[n] ? padOut[n] : (pullupEn[n] ? 1'b1 : extLevel[n]);
    end
  end
endmodule

/* tb_paoam_mux.sv */
// Self-checking bench for the port A override mux
`timescale 1ns/10ps
module tb_paoam_mux;
  import paoam_pkg::*;
  typedef struct packed {
    paoam_port_t port;
    paoam_port_t dir;
    logic [11:0] ctl;
    paoam_port_t eOut;
    paoam_port_t eOe;
    paoam_port_t ePull;
  } paoam_row_t;
  logic        core_clk = 1'b0;
  logic        rst_b = 1'b0;
  paoam_port_t portOut = 8'h00, dirBits = 8'h00, padIn, extLevel = 8'h00;
  logic        globalPullupDisable = 1'b0, sleepActive = 1'b0, referenceSelectLow = 1'b0;
  logic        converterEnable = 1'b0, comparatorEnable = 1'b0;
  paoam_chan_t converterChannelSelect = 3'h0;
  logic        wireModeHighBit = 1'b0, wireModeLowBit = 1'b0, serialDataOut = 1'b0;
  logic        serialDataLine = 1'b0, serialStartIrqEnable = 1'b0;
  logic        timer1CompareAOut = 1'b0, timer1CompareAEnable = 1'b0;
  logic        timer1CompareBOut = 1'b0, timer1CompareBEnable = 1'b0;
  logic        timer0CompareBOut = 1'b0, timer0CompareBEnable = 1'b0;
  paoam_port_t pinChangeMask = 8'h00, digitalInputDisable = 8'h00;
  logic        pinChangeGroup0Enable = 1'b0;
  paoam_port_t padOut, padOe, pullupEn, digInEn, pinChangeSrc, converterSwitch;
  logic        timer0CountInput, timer1CountInput, serialIfaceClock, serialDataIn;
  logic        timer1CaptureInput, comparatorPositiveInput, comparatorNegativeInput;
  int          n_fail = 0;
  int          compares = 0;
  paoam_row_t  rows [9];

  paoam_mux paoam_mux_i (.core_clk(core_clk), .rst_b(rst_b), .portOut(portOut), .dirBits(dirBits),
    .padIn(padIn), .globalPullupDisable(globalPullupDisable), .sleepActive(sleepActive),
    .referenceSelectLow(referenceSelectLow), .converterEnable(converterEnable),
    .converterChannelSelect(converterChannelSelect), .comparatorEnable(comparatorEnable),
    .wireModeHighBit(wireModeHighBit), .wireModeLowBit(wireModeLowBit), .serialDataOut(serialDataOut),
    .serialDataLine(serialDataLine), .serialStartIrqEnable(serialStartIrqEnable),
    .timer1CompareAOut(timer1CompareAOut), .timer1CompareAEnable(timer1CompareAEnable),
    .timer1CompareBOut(timer1CompareBOut), .timer1CompareBEnable(timer1CompareBEnable),
    .timer0CompareBOut(timer0CompareBOut), .timer0CompareBEnable(timer0CompareBEnable),
    .pinChangeMask(pinChangeMask), .pinChangeGroup0Enable(pinChangeGroup0Enable),
    .digitalInputDisable(digitalInputDisable), .padOut(padOut), .padOe(padOe), .pullupEn(pullupEn),
    .digInEn(digInEn), .pinChangeSrc(pinChangeSrc), .timer0CountInput(timer0CountInput),
    .timer1CountInput(timer1CountInput), .serialIfaceClock(serialIfaceClock),
    .serialDataIn(serialDataIn), .timer1CaptureInput(timer1CaptureInput),
    .converterSwitch(converterSwitch), .comparatorPositiveInput(comparatorPositiveInput),
    .comparatorNegativeInput(comparatorNegativeInput));
  paoam_pad_model paoam_pad_model_i (.padOut(padOut), .padOe(padOe), .pullupEn(pullupEn),
    .extLevel(extLevel), .padLevel(padIn));

  always #12.5 core_clk = ~core_clk;

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, seen);
      n_fail++;
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // Drives the input-enable controls and checks the resolved enables one edge later
  task automatic dien(input logic slp, input logic sie, input paoam_port_t msk, input paoam_port_t dis,
                      input paoam_port_t exp);
    @(posedge core_clk);
    sleepActive <= slp;
    pinChangeGroup0Enable <= 1'b1;
    serialStartIrqEnable <= sie;
    pinChangeMask <= msk;
    digitalInputDisable <= dis;
    cyc(1);
    check("digInEn", digInEn, exp);
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Run is under a hundred cycles; this is generous
  initial begin
    #(25 * 5000);
    n_fail++;
    report_and_stop;
  end

  initial begin
    // Ctl bits: pullDis ref wireHi wireLo dataOut line cmpA1 enA1 cmpB1 enB1 cmpB0 enB0
    rows[0] = {8'h0f, 8'h33, 12'h000, 8'h0f, 8'h33, 8'h0c};
    rows[1] = {8'h0f, 8'h33, 12'h800, 8'h0f, 8'h33, 8'h00};
    rows[2] = {8'hff, 8'h00, 12'h400, 8'hfe, 8'h00, 8'hfe};
    rows[3] = {8'h20, 8'h00, 12'h300, 8'h00, 8'h00, 8'h20};
    rows[4] = {8'h00, 8'h20, 12'h380, 8'h20, 8'h20, 8'h00};
    rows[5] = {8'h00, 8'h40, 12'h240, 8'h00, 8'h40, 8'h00};
    rows[6] = {8'h00, 8'h40, 12'h200, 8'h00, 8'h00, 8'h00};
    rows[7] = {8'h00, 8'he0, 12'h03f, 8'he0, 8'he0, 8'h00};
    rows[8] = {8'he0, 8'he0, 12'h015, 8'h00, 8'he0, 8'h00};
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    foreach (rows[i]) begin
      @(posedge core_clk);
      portOut <= rows[i].port;
      dirBits <= rows[i].dir;
      {globalPullupDisable, referenceSelectLow, wireModeHighBit, wireModeLowBit, serialDataOut,
       serialDataLine, timer1CompareAOut, timer1CompareAEnable, timer1CompareBOut,
       timer1CompareBEnable, timer0CompareBOut, timer0CompareBEnable} <= rows[i].ctl;
      cyc(1);
      check("padOut", padOut, rows[i].eOut);
      check("padOe", padOe, rows[i].eOe);
      check("pullupEn", pullupEn, rows[i].ePull);
    end
    dien(1'b1, 1'b0, 8'h00, 8'h00, 8'h00);
    dien(1'b1, 1'b0, 8'h0f, 8'h00, 8'h0f);
    dien(1'b0, 1'b0, 8'h0f, 8'hff, 8'h0f);
    dien(1'b1, 1'b1, 8'h00, 8'hff, 8'h40);
    dien(1'b0, 1'b0, 8'h00, 8'h00, 8'hff);
    // Comparator pins stay inputs with pull-ups off; all pins read the outside level
    @(posedge core_clk);
    {globalPullupDisable, referenceSelectLow, wireModeHighBit, wireModeLowBit, serialDataOut,
     serialDataLine, timer1CompareAOut, timer1CompareAEnable, timer1CompareBOut,
     timer1CompareBEnable, timer0CompareBOut, timer0CompareBEnable} <= 12'h800;
    dirBits <= 8'h00;
    for (int k = 0; k < 2; k++) begin
      @(posedge core_clk);
      extLevel <= (k == 0) ? 8'ha5 : 8'h5a;
      cyc(5);
      check("pinChangeSrc", pinChangeSrc, extLevel);
      check("timer0Count", {7'h00, timer0CountInput}, {7'h00, extLevel[3]});
      check("timer1Count", {7'h00, timer1CountInput}, {7'h00, extLevel[4]});
      check("serialClock", {7'h00, serialIfaceClock}, {7'h00, extLevel[4]});
      check("serialData", {7'h00, serialDataIn}, {7'h00, extLevel[6]});
      check("capture", {7'h00, timer1CaptureInput}, {7'h00, extLevel[7]});
    end
    for (int ch = 0; ch < 8; ch++) begin
      @(posedge core_clk);
      converterEnable <= 1'b1;
      converterChannelSelect <= ch[2:0];
      comparatorEnable <= 1'b1;
      cyc(1);
      check("converterSwitch", converterSwitch, 8'h01 << ch);
    end
    check("cmpPos", {7'h00, comparatorPositiveInput}, 8'h01);
    check("cmpNeg", {7'h00, comparatorNegativeInput}, 8'h01);
    @(posedge core_clk);
    converterEnable <= 1'b0;
    comparatorEnable <= 1'b0;
    portOut <= 8'hff;
    dirBits <= 8'h0f;
    cyc(1);
    check("converterOff", converterSwitch, 8'h00);
    check("cmpOff", {6'h00, comparatorNegativeInput, comparatorPositiveInput}, 8'h00);
    // Reset in mid-run clears every registered output
    @(posedge core_clk);
    rst_b <= 1'b0;
    cyc(1);
    check("rstPadOut", padOut, 8'h00);
    check("rstPadOe", padOe, 8'h00);
    check("rstPull", pullupEn, 8'h00);
    check("rstDigIn", digInEn, 8'h00);
    check("rstChange", pinChangeSrc, 8'h00);
    @(posedge core_clk);
    rst_b <= 1'b1;
    cyc(1);
    check("padOe", padOe, 8'h0f);
    report_and_stop;
  end
endmodule
